/* design/cmd_setup_map.svh */
`ifndef CMD_SETUP_MAP_SVH
`define CMD_SETUP_MAP_SVH
// ==========================================================
// command codes
`define CODE_ADDR_ENABLE 8'hD0
`define CODE_EP_ENABLE 8'hD8
`define CODE_SET_MODE 8'hF3
`define CODE_SET_DMA 8'hFB
// ==========================================================
// configuration byte fields
`define CFG_LAYOUT_HI 7
`define CFG_LAYOUT_LO 6
`define CFG_PULLUP 4
`define CFG_REPORT_ALL 3
`define CFG_CLK_RUN 2
`define CFG_NO_SLOW 1
`define CFG_USED_MASK 8'hDE
// ==========================================================
// divider byte fields
`define DIV_SOF_ONLY 7
`define DIV_DMA_PREP 6
`define DIV_N_HI 3
`define DIV_N_LO 0
`define DIV_USED_MASK 8'hCF
`define DIV_MAX_N 4'hB
// ==========================================================
// address byte fields and dma byte
`define ADDR_ENABLE_BIT 7
`define DMA_PIN_MODE 5
// ==========================================================
// reset values
`define CFG_RESET 8'h00
`define DIV_RESET 8'h0B
// ==========================================================
// timing: 1 ms suspend delay at 25 MHz (40 ns)
`define SUSPEND_DELAY_NS 1000000
`define CLK_PERIOD_NS 40
`define SUSPEND_DELAY_CYC (`SUSPEND_DELAY_NS / `CLK_PERIOD_NS)
// slow clock half period: about 30 kHz from 25 MHz
`define SLOW_HALF_CYC 417
`endif

/* design/cmd_setup_pkg.sv */
package cmd_setup_pkg;
   typedef enum logic [1:0] {
      LAYOUT_NON_ISO = 2'h0,
      LAYOUT_ISO_OUT = 2'h1,
      LAYOUT_ISO_IN  = 2'h2,
      LAYOUT_ISO_IO  = 2'h3
   } layout_t;
   typedef logic [7:0] byte_t;
endpackage

/* design/cmd_port_if.sv */
`timescale 1ns/1ps
// ==========================================================
// command/data port between microcontroller and device
interface cmd_port_if;
   logic       cmd_wr;   // one-cycle strobe: byte is a command code
   logic       data_wr;  // one-cycle strobe: byte is a data byte
   logic [7:0] wdata;
   modport device (input cmd_wr, input data_wr, input wdata);
   modport host (output cmd_wr, output data_wr, output wdata);
endinterface

/* design/setup_device.sv */
`timescale 1ns/1ps
`include "cmd_setup_map.svh"
// Operation
// - endpoint enable is D8 plus one byte
// - endpoints enable only when function enabled
// - mode F3: config byte then divider byte
// - config bits 7..6 pick endpoint layout
// - bit 4 connects pull-up when bus powered
// - bit 3 reports all errors and naks
// - bit 2 keeps clocks running in suspend
// - bit 1 low: slow clock 1 ms after suspend
// - bus reset keeps all mode settings
// - divider bit 7: interrupt on frame only
// - dma prep bit resets to zero
// - clock output is 48 MHz over N+1; at N=0 the output stays high
// - divider resets to 11
// - host writes divider 0 to 11 only
// - divider change makes no glitch
// - D0 byte sets address and enables function
// - dma bit 5 adds frame interrupt
module setup_device
   import cmd_setup_pkg::*;
(
   input  wire logic            clk_sys,
   input  wire logic            rst_n,
   input  wire logic            clk_48,
   cmd_port_if.device           port,
   input  wire logic            bus_reset,
   input  wire logic            vbus_present,
   input  wire logic            suspend_pin,
   input  wire logic            sof_event,
   input  wire logic            int_any,
   input  wire logic            err_nak_event,
   output logic [6:0]           usb_address,
   output logic                 function_enabled,
   output logic                 endpoints_enabled,
   output cmd_setup_pkg::layout_t layout,
   output logic                 pullup_connect,
   output logic                 report_all,
   output logic                 clocks_keep_running,
   output logic                 dma_prep_bit,
   output logic                 int_out,
   output logic                 divided_clock_output
);
   import cmd_setup_pkg::*;

   // ==========================================================
   // command decoding
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00, ST_ONE = 2'b01, ST_TWO = 2'b11, ST_ADDR = 2'b10
   } dstate_t;
   dstate_t state, next_state;
   logic [7:0] cfg, div, dma_cfg;
   logic [1:0] last_cmd;  // 0 ep enable, 1 mode, 2 dma

   wire is_ep   = port.cmd_wr && port.wdata == `CODE_EP_ENABLE;
   wire is_mode = port.cmd_wr && port.wdata == `CODE_SET_MODE;
   wire is_addr = port.cmd_wr && port.wdata == `CODE_ADDR_ENABLE;
   wire is_dma  = port.cmd_wr && port.wdata == `CODE_SET_DMA;
   wire take_cfg  = port.data_wr && state == ST_ONE && last_cmd == 2'h1;
   wire take_div  = port.data_wr && state == ST_TWO;
   wire take_ep   = port.data_wr && state == ST_ONE && last_cmd == 2'h0;
   wire take_dmac = port.data_wr && state == ST_ONE && last_cmd == 2'h2;
   wire take_addr = port.data_wr && state == ST_ADDR;

   always_comb begin
      next_state = state;
      if (port.cmd_wr) begin
         if (is_addr)
            next_state = ST_ADDR;
         else if (is_ep || is_mode || is_dma)
            next_state = ST_ONE;
         else
            next_state = ST_IDLE;
      end else if (port.data_wr) begin
         unique case (state)
            ST_ONE:  next_state = take_cfg ? ST_TWO : ST_IDLE;
            ST_TWO:  next_state = ST_IDLE;
            ST_ADDR: next_state = ST_IDLE;
            ST_IDLE: next_state = ST_IDLE;
         endcase
      end
   end

   // state and command memory
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state    <= ST_IDLE;
         last_cmd <= 2'h0;
      end else begin
         state <= next_state;
         if (port.cmd_wr)
            last_cmd <= is_mode ? 2'h1 : (is_dma ? 2'h2 : 2'h0);
      end
   end

   // ==========================================================
   // registers; bus_reset deliberately not used here
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cfg               <= `CFG_RESET;
         div               <= `DIV_RESET;
         dma_cfg           <= 8'h00;
         usb_address       <= 7'h00;
         function_enabled  <= 1'b0;
         endpoints_enabled <= 1'b0;
      end else begin
         if (take_cfg)
            cfg <= port.wdata & `CFG_USED_MASK;
         if (take_div)
            div <= port.wdata & `DIV_USED_MASK;
         if (take_dmac)
            dma_cfg <= port.wdata;
         if (take_addr) begin
            usb_address      <= port.wdata[6:0];
            function_enabled <= port.wdata[`ADDR_ENABLE_BIT];
         end
         if (take_ep)
            endpoints_enabled <= port.wdata[0] && function_enabled;
         else if (!function_enabled)
            endpoints_enabled <= 1'b0;
      end
   end

   // ==========================================================
   // outputs derived from settings
   wire [1:0] lay_w = cfg[`CFG_LAYOUT_HI:`CFG_LAYOUT_LO];
   wire sof_only = div[`DIV_SOF_ONLY];
   wire sof_pin  = dma_cfg[`DMA_PIN_MODE];
   wire any_int  = int_any || (report_all && err_nak_event);
   wire next_int = sof_only ? sof_event
                 : (any_int || (sof_pin && sof_event));

   // input synchroniser for suspend pin (three flops)
   logic [2:0] susp_sync;
   logic       susp_level;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         susp_sync  <= 3'h0;
         susp_level <= 1'b0;
      end else begin
         susp_sync <= {susp_sync[1:0], suspend_pin};
         if (susp_sync[1] == susp_sync[2])
            susp_level <= susp_sync[2];
      end
   end

   // suspend delay counter and slow clock
   logic [15:0] susp_cnt;
   logic        slow_sel;
   logic [9:0]  slow_cnt;
   logic        slow_clk;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         susp_cnt <= 16'h0000;
         slow_sel <= 1'b0;
      end else if (!susp_level || cfg[`CFG_NO_SLOW]) begin
         susp_cnt <= 16'h0000;
         slow_sel <= 1'b0;
      end else if (susp_cnt == 16'(`SUSPEND_DELAY_CYC - 1)) begin
         slow_sel <= 1'b1;
      end else begin
         susp_cnt <= susp_cnt + 16'h0001;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         slow_cnt <= 10'h000;
         slow_clk <= 1'b0;
      end else if (slow_cnt == 10'(`SLOW_HALF_CYC - 1)) begin
         slow_cnt <= 10'h000;
         slow_clk <= ~slow_clk;
      end else begin
         slow_cnt <= slow_cnt + 10'h001;
      end
   end

   // registered outputs
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         layout              <= LAYOUT_NON_ISO;
         pullup_connect      <= 1'b0;
         report_all          <= 1'b0;
         clocks_keep_running <= 1'b0;
         dma_prep_bit        <= 1'b0;
         int_out             <= 1'b0;
      end else begin
         layout              <= layout_t'(lay_w);
         pullup_connect      <= cfg[`CFG_PULLUP] && vbus_present;
         report_all          <= cfg[`CFG_REPORT_ALL];
         clocks_keep_running <= cfg[`CFG_CLK_RUN];
         dma_prep_bit        <= div[`DIV_DMA_PREP];
         int_out             <= next_int;
      end
   end

   // ==========================================================
   // 48 MHz divider: new N takes effect only at period end
   // the divider word crosses clocks: taken once two samples agree
   logic [3:0] n_sync1, n_sync2, n_sync3, n_new, n_act, div_cnt;
   logic       fast_clk;
   always_ff @(posedge clk_48 or negedge rst_n) begin
      if (!rst_n) begin
         n_sync1  <= `DIV_MAX_N;
         n_sync2  <= `DIV_MAX_N;
         n_sync3  <= `DIV_MAX_N;
         n_new    <= `DIV_MAX_N;
         n_act    <= `DIV_MAX_N;
         div_cnt  <= 4'h0;
         fast_clk <= 1'b1;
      end else begin
         n_sync1 <= div[`DIV_N_HI:`DIV_N_LO];
         n_sync2 <= n_sync1;
         n_sync3 <= n_sync2;
         if (n_sync2 == n_sync3)
            n_new <= n_sync3;
         if (div_cnt >= n_act) begin
            div_cnt  <= 4'h0;
            n_act    <= n_new;
            fast_clk <= 1'b1;
         end else begin
            div_cnt  <= div_cnt + 4'h1;
            fast_clk <= (div_cnt + 4'h1) < ((n_act + 4'h1) >> 1);
         end
      end
   end

   // output select on clk_48; switches only while both are low
   // select and slow clock cross from clk_sys through three flops each
   logic       use_slow;
   logic       slow_q;
   logic [2:0] slow_s;
   logic [2:0] slow_c;
   wire        both_low = !fast_clk && !slow_q && !divided_clock_output;
   always_ff @(posedge clk_48 or negedge rst_n) begin
      if (!rst_n) begin
         slow_s               <= 3'h0;
         slow_c               <= 3'h0;
         slow_q               <= 1'b0;
         use_slow             <= 1'b0;
         divided_clock_output <= 1'b1;
      end else begin
         slow_s <= {slow_s[1:0], slow_sel};
         slow_c <= {slow_c[1:0], slow_clk};
         if (slow_c[1] == slow_c[2])
            slow_q <= slow_c[2];
         if (both_low && slow_s[1] == slow_s[2])
            use_slow <= slow_s[2];
         divided_clock_output <= use_slow ? slow_q : fast_clk;
      end
   end
endmodule

/* design/setup_host.sv */
`timescale 1ns/1ps
`include "cmd_setup_map.svh"
// ==========================================================
// microcontroller end: issues setup sequences from user requests
module setup_host
   import cmd_setup_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   cmd_port_if.host        port,
   input  wire logic       req_ep_enable,
   input  wire logic       req_mode,
   input  wire logic [7:0] ep_byte,
   input  wire logic [7:0] cfg_byte,
   input  wire logic [7:0] div_byte,
   output logic            busy
);
   import cmd_setup_pkg::*;

   typedef enum logic [1:0] {
      H_IDLE = 2'b00, H_D1 = 2'b01, H_D2 = 2'b11
   } hstate_t;
   hstate_t    state;
   logic       mode_cmd;
   logic [7:0] b1, b2;
   logic [3:0] n_in;
   logic [3:0] n_ok;

   // clamp divider to the permitted range, zero spare bits
   assign n_in = div_byte[`DIV_N_HI:`DIV_N_LO];
   assign n_ok = (n_in > `DIV_MAX_N) ? `DIV_MAX_N : n_in;

   // sequencer: command then one or two data bytes
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state        <= H_IDLE;
         mode_cmd     <= 1'b0;
         b1           <= 8'h00;
         b2           <= 8'h00;
         port.cmd_wr  <= 1'b0;
         port.data_wr <= 1'b0;
         port.wdata   <= 8'h00;
         busy         <= 1'b0;
      end else begin
         port.cmd_wr  <= 1'b0;
         port.data_wr <= 1'b0;
         unique case (state)
            H_IDLE: begin
               if (req_mode) begin
                  port.cmd_wr <= 1'b1;
                  port.wdata  <= `CODE_SET_MODE;
                  b1       <= cfg_byte & `CFG_USED_MASK;
                  b2       <= {div_byte[`DIV_SOF_ONLY], 1'b1,
                               2'b00, n_ok};
                  mode_cmd <= 1'b1;
                  state    <= H_D1;
                  busy     <= 1'b1;
               end else if (req_ep_enable) begin
                  port.cmd_wr <= 1'b1;
                  port.wdata  <= `CODE_EP_ENABLE;
                  b1       <= ep_byte;
                  mode_cmd <= 1'b0;
                  state    <= H_D1;
                  busy     <= 1'b1;
               end
            end
            H_D1: begin
               port.data_wr <= 1'b1;
               port.wdata   <= b1;
               state        <= mode_cmd ? H_D2 : H_IDLE;
               busy         <= mode_cmd;
            end
            H_D2: begin
               port.data_wr <= 1'b1;
               port.wdata   <= b2;
               state        <= H_IDLE;
               busy         <= 1'b0;
            end
            default: state <= H_IDLE;
         endcase
      end
   end
endmodule

/* bench/setup_asserts.sv */
`timescale 1ns/1ps
// ==========================================================
// checks on the port joining host end and device end
module setup_asserts
   import cmd_setup_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       rst_n,
   input wire logic       cmd_wr,
   input wire logic       data_wr,
   input wire logic [7:0] wdata,
   input wire logic       bus_reset,
   input wire logic       vbus_present,
   input wire logic       int_any,
   input wire logic       err_nak_event,
   input wire logic       sof_event,
   input wire cmd_setup_pkg::layout_t layout,
   input wire logic       pullup_connect,
   input wire logic       report_all,
   input wire logic       clocks_keep_running,
   input wire logic       dma_prep_bit,
   input wire logic       int_out,
   input wire logic       function_enabled,
   input wire logic       endpoints_enabled
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // mode write: settings follow the two data bytes
   property p_mode_layout;
      logic [7:0] c;
      (cmd_wr && wdata == 8'hF3) ##1 (data_wr, c = wdata) ##1 data_wr
         |-> ##2 (layout == c[7:6]);
   endproperty
   a_mode_layout: assert property (p_mode_layout)
      else $error("layout differs from config byte");
   property p_mode_bits;
      logic [7:0] c;
      (cmd_wr && wdata == 8'hF3) ##1 (data_wr, c = wdata) ##1 data_wr
         |-> ##2 (report_all == c[3] && clocks_keep_running == c[2]
         && pullup_connect == (c[4] & $past(vbus_present)));
   endproperty
   a_mode_bits: assert property (p_mode_bits)
      else $error("config bits not applied");
   property p_mode_prep;
      logic [7:0] d;
      (cmd_wr && wdata == 8'hF3) ##1 data_wr ##1 (data_wr, d = wdata)
         |-> ##2 (dma_prep_bit == d[6]);
   endproperty
   a_mode_prep: assert property (p_mode_prep)
      else $error("dma prep bit not from divider byte");
   // ==========================================================
   // pull-up, bus reset and reset values
   property p_no_vbus;
      !$past(vbus_present) |-> !pullup_connect;
   endproperty
   a_no_vbus: assert property (p_no_vbus)
      else $error("pull-up connected without bus power");
   property p_bus_keep;
      bus_reset && !data_wr && !$past(data_wr) && $stable(vbus_present)
         |=> $stable({layout, pullup_connect, report_all,
         clocks_keep_running, dma_prep_bit});
   endproperty
   a_bus_keep: assert property (p_bus_keep)
      else $error("settings changed on bus reset");
   property p_reset_val;
      $rose(rst_n) |-> !dma_prep_bit && !pullup_connect
         && layout == LAYOUT_NON_ISO;
   endproperty
   a_reset_val: assert property (p_reset_val)
      else $error("wrong value after reset");
   // ==========================================================
   // command framing, endpoint gating and interrupt cause
   property p_ep_refuse;
      (cmd_wr && wdata == 8'hD8) ##1 (data_wr && !function_enabled)
         |-> ##2 !endpoints_enabled;
   endproperty
   a_ep_refuse: assert property (p_ep_refuse)
      else $error("endpoints enabled while function off");
   property p_f3_order;
      cmd_wr && wdata == 8'hF3 |=> data_wr ##1 data_wr;
   endproperty
   a_f3_order: assert property (p_f3_order)
      else $error("mode command not followed by two bytes");
   property p_d8_one;
      cmd_wr && wdata == 8'hD8 |=> data_wr ##1 !data_wr;
   endproperty
   a_d8_one: assert property (p_d8_one)
      else $error("endpoint command not followed by one byte");
   property p_int_cause;
      int_out |-> $past(int_any) || $past(err_nak_event)
         || $past(sof_event);
   endproperty
   a_int_cause: assert property (p_int_cause)
      else $error("interrupt without cause");
   c_mode: cover property ((cmd_wr && wdata == 8'hF3) ##1 data_wr);
   c_ep: cover property ((cmd_wr && wdata == 8'hD8) ##1 data_wr);
   c_int: cover property (err_nak_event ##1 int_out);
   c_bus: cover property (bus_reset ##1 bus_reset);
endmodule

/* bench/endpoint_enable_and_mode_setup_tb.sv */
`timescale 1ns/1ps
// ==========================================================
// host end drives device end; second device from a raw driver
module endpoint_enable_and_mode_setup_tb;
   import cmd_setup_pkg::*;
   typedef struct {int sel; logic [15:0] exp;} note_t;
   logic       clk_sys, rst_n, clk_48, bus_reset, vbus_present;
   logic       suspend_pin, sof_event, int_any, err_nak_event;
   logic       req_ep_enable, req_mode, busy, dco;
   logic [7:0] ep_byte, cfg_byte, div_byte, cfg, dv;
   layout_t    layout;
   logic       pullup_connect, report_all, clocks_keep_running;
   logic       dma_prep_bit, int_out, fen1, een1, fen2, een2, int2;
   logic [6:0] addr2;
   logic [15:0] e, g;
   note_t      notes[$];
   note_t      n;
   event       shown;
   int         fail_count, num_checks, cyc, c48, per, seed;
   string      nm[5] = '{"settings", "endpoint", "period", "slow", "busy"};
   cmd_port_if p1 ();
   cmd_port_if p2 ();
   setup_host u_setup_host (.clk_sys, .rst_n, .port(p1.host),
      .req_ep_enable, .req_mode, .ep_byte, .cfg_byte, .div_byte, .busy);
   setup_device u_setup_device (.clk_sys, .rst_n, .clk_48,
      .port(p1.device), .bus_reset, .vbus_present, .suspend_pin,
      .sof_event, .int_any, .err_nak_event, .usb_address(),
      .function_enabled(fen1), .endpoints_enabled(een1), .layout,
      .pullup_connect, .report_all, .clocks_keep_running, .dma_prep_bit,
      .int_out, .divided_clock_output(dco));
   setup_device u_setup_device_2 (.clk_sys, .rst_n, .clk_48,
      .port(p2.device), .bus_reset, .vbus_present, .suspend_pin,
      .sof_event, .int_any, .err_nak_event, .usb_address(addr2),
      .function_enabled(fen2), .endpoints_enabled(een2), .layout(),
      .pullup_connect(), .report_all(), .clocks_keep_running(),
      .dma_prep_bit(), .int_out(int2), .divided_clock_output());
   setup_asserts u_setup_asserts (.clk_sys, .rst_n, .cmd_wr(p1.cmd_wr),
      .data_wr(p1.data_wr), .wdata(p1.wdata), .bus_reset, .vbus_present,
      .int_any, .err_nak_event, .sof_event, .layout, .pullup_connect,
      .report_all, .clocks_keep_running, .dma_prep_bit, .int_out,
      .function_enabled(fen1), .endpoints_enabled(een1));
   // clocks, clk_48 cycle count and hang limit
   initial begin
      clk_sys = 0;
      forever #20 clk_sys = ~clk_sys;
   end
   initial begin
      clk_48 = 0;
      forever #10.417 clk_48 = ~clk_48;
   end
   always @(posedge clk_48) c48++;
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 60000) begin
         fail_count++;
         give_verdict();
      end
   end
   // observed value for each kind of note
   function automatic logic [15:0] obs(int s);
      case (s)
         0: return {7'h00, layout, pullup_connect, report_all,
                    clocks_keep_running, dma_prep_bit, int_out, een1, 1'b0};
         1: return {3'h0, addr2, fen2, een2, int2, 3'h0};
         2: return per[15:0];
         3: return {15'h0000, per > 1000};
         default: return {15'h0000, busy};
      endcase
   endfunction
   // monitor: oldest note against what the outputs show
   initial forever begin
      @(shown);
      n = notes.pop_front();
      g = obs(n.sel);
      num_checks++;
      if (g !== n.exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm[n.sel], n.exp, g);
      end
   end
   task automatic note(int s, logic [15:0] x);
      notes.push_back('{s, x});
      -> shown;
      #1;
   endtask
   task automatic tick(int k);
      repeat (k) @(posedge clk_sys);
      #2;
   endtask
   task automatic done(string s);
      $display("test %s finished", s);
   endtask
   task automatic mode_wr(logic [7:0] c, logic [7:0] d);
      cfg_byte = c;
      div_byte = d;
      req_mode = 1;
      tick(1);
      req_mode = 0;
      note(4, 16'h0001);
      tick(6);
   endtask
   // one-cycle event pulse, result looked at after the sampling edge
   task automatic pulse(logic ia, logic en, logic sf, int s,
                        logic [15:0] x);
      int_any = ia;
      err_nak_event = en;
      sof_event = sf;
      @(posedge clk_sys);
      #1;
      note(s, x);
      int_any = 0;
      err_nak_event = 0;
      sof_event = 0;
   endtask
   // divided clock period in clk_48 cycles
   task automatic meas;
      int a;
      @(posedge dco);
      a = c48;
      @(posedge dco);
      per = c48 - a;
      tick(1);
   endtask
   // raw command on the second port; released data is inverted
   task automatic send(logic [7:0] c, logic [7:0] b0, logic [7:0] b1,
                       int k);
      p2.cmd_wr = 1;
      p2.wdata = c;
      tick(1);
      p2.cmd_wr = 0;
      for (int i = 0; i < k; i++) begin
         p2.data_wr = 1;
         p2.wdata = (i == 0) ? b0 : b1;
         tick(1);
      end
      p2.data_wr = 0;
      p2.wdata = ~p2.wdata;
      tick(3);
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // main sequence
   initial begin
      seed = 32'hEAD1;
      {rst_n, bus_reset, suspend_pin, sof_event, int_any} = 5'h00;
      {err_nak_event, req_ep_enable, req_mode} = 3'h0;
      vbus_present = 1;
      {ep_byte, cfg_byte, div_byte} = {8'h01, 16'h0000};
      {p2.cmd_wr, p2.data_wr, p2.wdata} = 10'h000;
      repeat (12) @(posedge clk_sys);
      #2 rst_n = 1;
      tick(2);
      note(0, 16'h0000);
      meas;
      note(2, 16'h000C);
      req_ep_enable = 1;
      tick(1);
      req_ep_enable = 0;
      tick(6);
      note(0, 16'h0000);
      done("reset");
      for (int i = 0; i < 4; i++) begin
         cfg = 8'($random(seed));
         dv = 8'($random(seed));
         cfg[7:6] = i[1:0];
         dv[3:0] = 4'(1 + {$random(seed)} % 11);
         mode_wr(cfg, dv);
         e = {7'h00, cfg[7:6], cfg[4:2], 1'b1, cfg[3] & ~dv[7], 2'b00};
         pulse(0, 1, 0, 0, e);
         meas;
         meas;
         note(2, 16'(dv[3:0]) + 16'h0001);
      end
      done("mode");
      e[2] = 0;
      bus_reset = 1;
      tick(5);
      note(0, e);
      meas;
      note(2, 16'(dv[3:0]) + 16'h0001);
      bus_reset = 0;
      vbus_present = 0;
      tick(2);
      e[6] = 0;
      note(0, e);
      done("bus reset");
      send(8'hD8, 8'h01, 8'h00, 1);
      note(1, 16'h0000);
      send(8'hD0, 8'hA5, 8'h00, 1);
      send(8'hD8, 8'h01, 8'h00, 1);
      note(1, {3'h0, 7'h25, 3'h6, 3'h0});
      for (int i = 0; i < 4; i++) begin
         send(8'hF3, 8'h00, (i < 2) ? 8'h8B : 8'h0B, 2);
         send(8'hFB, (i == 2) ? 8'h20 : 8'h00, 8'h00, 1);
         pulse(i == 0, 0, i > 0, 1,
               {3'h0, 7'h25, 2'b11, i == 1 || i == 2, 3'h0});
      end
      done("interrupt");
      mode_wr(8'h00, 8'h42);
      meas;
      meas;
      note(2, 16'h0003);
      suspend_pin = 1;
      tick(24000);
      meas;
      note(2, 16'h0003);
      tick(2000);
      meas;
      meas;
      note(3, 16'h0001);
      done("slow clock");
      give_verdict();
   end
endmodule
